// file: rtl/cfg_cmd_pkg.sv
// Constants and types shared by the configure command processor and its parameter store.
package cfg_cmd_pkg;

  // ****************************************************************
  // Register map (byte addresses on the Wishbone bus)
  // ****************************************************************
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_CB_ADDR  = 8'h04;
  localparam logic [7:0] REG_STATUS   = 8'h08;
  localparam logic [7:0] REG_IRQ_STAT = 8'h0C;
  localparam logic [7:0] REG_IRQ_MASK = 8'h10;
  localparam logic [7:0] REG_CFG_IDX  = 8'h14;
  localparam logic [7:0] REG_CFG_DATA = 8'h18;

  localparam int CTRL_START_BIT  = 0;
  localparam int CTRL_CNA_SUSP   = 1;
  localparam int IRQ_CX_BIT      = 0;
  localparam int IRQ_CNA_BIT     = 1;
  localparam int IRQ_W           = 2;
  localparam int STAT_LINK_BIT   = 2;
  localparam int STAT_PHYW_BIT   = 3;
  localparam int STAT_PHYS_BIT   = 4;
  localparam int STAT_BAD_BIT    = 5;

  // ****************************************************************
  // Command block layout
  // ****************************************************************
  localparam logic [2:0]  CMD_CONFIGURE   = 3'h2;
  localparam int          CMD_LSB         = 16;
  localparam int          EOL_BIT         = 31;
  localparam int          SUSPEND_BIT     = 30;
  localparam int          INTR_BIT        = 29;
  localparam int          DONE_BIT        = 15;
  localparam int          OK_BIT          = 13;
  localparam logic [31:0] CFG_WORD_OFFSET = 32'h0000_0008;
  localparam logic [4:0]  CFG_MIN_BYTES   = 5'h08;
  localparam logic [4:0]  CFG_MAX_BYTES   = 5'h16;
  localparam logic [4:0]  CU_BYTES        = 5'h08;
  localparam logic [4:0]  PHY_BYTE        = 5'h08;
  localparam int          PHY_BIT         = 0;
  localparam logic [2:0]  RXDMA_BYTE      = 3'h4;
  localparam int          RXDMA_W         = 7;

  // Power-up values of the eight command-unit bytes, byte 0 in the low lane.
  localparam logic [63:0] CU_CFG_DEFAULT  = 64'h0032_0000_0000_0816;
  localparam logic [6:0]  RXDMA_DEFAULT   = 7'h00;

  typedef enum logic [1:0] {
    CU_IDLE      = 2'h0,
    CU_ACTIVE    = 2'h1,
    CU_SUSPENDED = 2'h2
  } cu_state_t;

  typedef enum logic [2:0] {
    ST_IDLE      = 3'h0,
    ST_FETCH_CMD = 3'h1,
    ST_FETCH_CFG = 3'h3,
    ST_SEND      = 3'h2,
    ST_WRITE_ST  = 3'h6,
    ST_FINISH    = 3'h7
  } seq_state_t;

endpackage : cfg_cmd_pkg

// file: rtl/cfg_store_if.sv
// Interface between the command sequencer and the command-unit parameter store.
`timescale 1ns/1ps
interface cfg_store_if;
  logic       we;
  logic [2:0] waddr;
  logic [7:0] wdata;
  logic [2:0] raddr;
  logic [7:0] rdata;

  modport owner (output we, output waddr, output wdata, output raddr, input rdata);
  modport store (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : cfg_store_if

// file: rtl/cu_param_store.sv
// Eight-byte command-unit parameter store with reset defaults and a registered read port.
`timescale 1ns/1ps
module cu_param_store #(
  parameter logic [63:0] DEFAULTS = cfg_cmd_pkg::CU_CFG_DEFAULT
) (
  input  wire logic   clk,     // System clock.
  input  wire logic   arst_n,  // Asynchronous reset, active low.
  cfg_store_if.store  bus      // Write and read port.
);

  logic [7:0] mem_ff [8];
  logic [7:0] nxt_mem [8];
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;

  // Unwritten entries keep their values; the count is clamped to at least eight, so every configure block writes all eight entries.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      nxt_mem[i] = mem_ff[i];
    end
    if (bus.we) begin
      nxt_mem[bus.waddr] = bus.wdata;
    end
    nxt_rdata = mem_ff[bus.raddr];
  end

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_entry
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          mem_ff[g] <= DEFAULTS[8*g +: 8];
        end else begin
          mem_ff[g] <= nxt_mem[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign bus.rdata = rdata_ff;

endmodule : cu_param_store

// file: rtl/configure_command_processor.sv
// Command-unit sequencer that executes configure command blocks fetched from host memory.
// What this block does
// - Command code 010b means load operating parameters.
// - Accept at most 22 bytes, ignore beyond.
// - First eight bytes go to own storage.
// - Later bytes stream to the execution unit.
// - Unsupplied parameters keep their default values; count is clamped to eight minimum, so bytes 0-7 always load.
// - First generation: block link until PHY bit written.
// - Later generations: block link until PHY bit one.
// - Byte 4 low bits give receive DMA limit.
// - Set completion bit 15 in status word.
// - End-of-list: go idle, always raise not-active.
// - Suspend bit: suspend, optional not-active event.
// - Interrupt bit raises command-executed event, else none.
`timescale 1ns/1ps
module configure_command_processor #(
  parameter bit LATER_GEN = 1'b1
) (
  input  wire logic        CLOCK,       // System clock, 125 MHz.
  input  wire logic        ARST_N,      // Asynchronous reset, active low.
  input  wire logic        WB_CYC_I,    // Wishbone cycle.
  input  wire logic        WB_STB_I,    // Wishbone strobe.
  input  wire logic        WB_WE_I,     // Wishbone write enable.
  input  wire logic [7:0]  WB_ADR_I,    // Wishbone byte address.
  input  wire logic [3:0]  WB_SEL_I,    // Wishbone byte selects.
  input  wire logic [31:0] WB_DAT_I,    // Wishbone write data.
  output logic      [31:0] WB_DAT_O,    // Wishbone read data.
  output logic             WB_ACK_O,    // Wishbone acknowledge.
  output logic             MEM_REQ,     // Host memory request, held until MEM_ACK.
  output logic             MEM_WE,      // Host memory write when high.
  output logic      [31:0] MEM_ADDR,    // Host memory byte address.
  output logic      [31:0] MEM_WDATA,   // Host memory write data.
  input  wire logic        MEM_ACK,     // Host memory acknowledge, one cycle.
  input  wire logic [31:0] MEM_RDATA,   // Host memory read data, valid with MEM_ACK.
  output logic             TX_VALID,    // Parameter byte for the execution unit valid.
  output logic      [7:0]  TX_DATA,     // Parameter byte for the execution unit.
  input  wire logic        TX_READY,    // Execution unit takes the byte.
  output logic      [6:0]  RX_DMA_MAX,  // Receive DMA maximum byte count.
  output logic             LINK_EN,     // Frame transmit and receive allowed.
  output logic      [1:0]  CU_STATE,    // Command unit state.
  output logic             IRQ          // Interrupt, high while an unmasked event is pending.
);

  // ****************************************************************
  // State
  // ****************************************************************
  cfg_cmd_pkg::seq_state_t st_ff, nxt_st;
  cfg_cmd_pkg::cu_state_t  cu_ff, nxt_cu;
  logic [31:0] cb_addr_ff, nxt_cb_addr;
  logic [31:0] cmd_ff, nxt_cmd;
  logic [31:0] word_ff, nxt_word;
  logic [4:0]  idx_ff, nxt_idx;
  logic [4:0]  cnt_ff, nxt_cnt;
  logic        bad_ff, nxt_bad;
  logic        req_ff, nxt_req;
  logic        we_ff, nxt_we;
  logic [31:0] addr_ff, nxt_addr;
  logic [31:0] wdata_ff, nxt_wdata;
  logic        txv_ff, nxt_txv;
  logic [7:0]  txd_ff, nxt_txd;
  logic [6:0]  rxmax_ff, nxt_rxmax;
  logic        phyw_ff, nxt_phyw;
  logic        phys_ff, nxt_phys;
  logic        link_ff, nxt_link;
  logic        cna_susp_ff, nxt_cna_susp;
  logic [cfg_cmd_pkg::IRQ_W-1:0] ist_ff, nxt_ist;
  logic [cfg_cmd_pkg::IRQ_W-1:0] imask_ff, nxt_imask;
  logic [cfg_cmd_pkg::IRQ_W-1:0] iset;
  logic        irq_ff, nxt_irq;
  logic [2:0]  cfg_idx_ff, nxt_cfg_idx;
  logic        ack_ff, nxt_ack;
  logic [31:0] rd_ff, nxt_rd;
  logic        start;
  logic        wb_req;
  logic [7:0]  cur_byte;
  logic [4:0]  idx_inc;

  cfg_store_if store_bus ();

  cu_param_store #(
    .DEFAULTS (cfg_cmd_pkg::CU_CFG_DEFAULT)
  ) u_store (
    .clk    (CLOCK),
    .arst_n (ARST_N),
    .bus    (store_bus.store)
  );

  // ****************************************************************
  // Register bus
  // ****************************************************************
  // Every access is acknowledged one cycle after the strobe; unmapped offsets read zero.
  assign wb_req = WB_CYC_I & WB_STB_I & ~ack_ff;
  assign start  = wb_req & WB_WE_I & WB_SEL_I[0] & (WB_ADR_I == cfg_cmd_pkg::REG_CTRL)
                  & WB_DAT_I[cfg_cmd_pkg::CTRL_START_BIT];

  always_comb begin
    nxt_ack      = wb_req;
    nxt_rd       = 32'h0000_0000;
    nxt_cb_addr  = cb_addr_ff;
    nxt_cna_susp = cna_susp_ff;
    nxt_imask    = imask_ff;
    nxt_cfg_idx  = cfg_idx_ff;
    nxt_ist      = ist_ff;
    if (wb_req && WB_WE_I) begin
      case (WB_ADR_I)
        cfg_cmd_pkg::REG_CTRL: begin
          if (WB_SEL_I[0]) begin
            nxt_cna_susp = WB_DAT_I[cfg_cmd_pkg::CTRL_CNA_SUSP];
          end
        end
        cfg_cmd_pkg::REG_CB_ADDR: begin
          for (int b = 0; b < 4; b++) begin
            if (WB_SEL_I[b]) begin
              nxt_cb_addr[8*b +: 8] = WB_DAT_I[8*b +: 8];
            end
          end
        end
        cfg_cmd_pkg::REG_IRQ_STAT: begin
          if (WB_SEL_I[0]) begin
            nxt_ist = ist_ff & ~WB_DAT_I[cfg_cmd_pkg::IRQ_W-1:0];
          end
        end
        cfg_cmd_pkg::REG_IRQ_MASK: begin
          if (WB_SEL_I[0]) begin
            nxt_imask = WB_DAT_I[cfg_cmd_pkg::IRQ_W-1:0];
          end
        end
        cfg_cmd_pkg::REG_CFG_IDX: begin
          if (WB_SEL_I[0]) begin
            nxt_cfg_idx = WB_DAT_I[2:0];
          end
        end
        default: begin
        end
      endcase
    end else if (wb_req) begin
      case (WB_ADR_I)
        cfg_cmd_pkg::REG_CTRL:     nxt_rd[cfg_cmd_pkg::CTRL_CNA_SUSP] = cna_susp_ff;
        cfg_cmd_pkg::REG_CB_ADDR:  nxt_rd = cb_addr_ff;
        cfg_cmd_pkg::REG_STATUS: begin
          nxt_rd[1:0]                        = cu_ff;
          nxt_rd[cfg_cmd_pkg::STAT_LINK_BIT] = link_ff;
          nxt_rd[cfg_cmd_pkg::STAT_PHYW_BIT] = phyw_ff;
          nxt_rd[cfg_cmd_pkg::STAT_PHYS_BIT] = phys_ff;
          nxt_rd[cfg_cmd_pkg::STAT_BAD_BIT]  = bad_ff;
        end
        cfg_cmd_pkg::REG_IRQ_STAT: nxt_rd[cfg_cmd_pkg::IRQ_W-1:0] = ist_ff;
        cfg_cmd_pkg::REG_IRQ_MASK: nxt_rd[cfg_cmd_pkg::IRQ_W-1:0] = imask_ff;
        cfg_cmd_pkg::REG_CFG_IDX:  nxt_rd[2:0] = cfg_idx_ff;
        cfg_cmd_pkg::REG_CFG_DATA: nxt_rd[7:0] = store_bus.rdata;
        default:                   nxt_rd = 32'h0000_0000;
      endcase
    end
    // A new event wins over a clear written in the same cycle.
    nxt_ist = nxt_ist | iset;
    nxt_irq = |(nxt_ist & nxt_imask);
  end

  // ****************************************************************
  // Command sequencer
  // ****************************************************************
  assign cur_byte = word_ff[8*idx_ff[1:0] +: 8];
  assign idx_inc  = idx_ff + 5'h01;

  always_comb begin
    nxt_st    = st_ff;
    nxt_cu    = cu_ff;
    nxt_cmd   = cmd_ff;
    nxt_word  = word_ff;
    nxt_idx   = idx_ff;
    nxt_cnt   = cnt_ff;
    nxt_bad   = bad_ff;
    nxt_req   = req_ff;
    nxt_we    = we_ff;
    nxt_addr  = addr_ff;
    nxt_wdata = wdata_ff;
    nxt_txv   = txv_ff;
    nxt_txd   = txd_ff;
    nxt_rxmax = rxmax_ff;
    nxt_phyw  = phyw_ff;
    nxt_phys  = phys_ff;
    iset      = '0;
    store_bus.we    = 1'b0;
    store_bus.waddr = idx_ff[2:0];
    store_bus.wdata = cur_byte;
    store_bus.raddr = cfg_idx_ff;
    case (st_ff)
      cfg_cmd_pkg::ST_IDLE: begin
        // A start while the unit is busy is ignored.
        if (start) begin
          nxt_st   = cfg_cmd_pkg::ST_FETCH_CMD;
          nxt_cu   = cfg_cmd_pkg::CU_ACTIVE;
          nxt_req  = 1'b1;
          nxt_we   = 1'b0;
          nxt_addr = cb_addr_ff;
          nxt_idx  = 5'h00;
        end
      end
      cfg_cmd_pkg::ST_FETCH_CMD: begin
        if (MEM_ACK) begin
          nxt_cmd = MEM_RDATA;
          nxt_req = 1'b0;
          if (MEM_RDATA[cfg_cmd_pkg::CMD_LSB +: 3] == cfg_cmd_pkg::CMD_CONFIGURE) begin
            nxt_bad  = 1'b0;
            nxt_st   = cfg_cmd_pkg::ST_FETCH_CFG;
            nxt_req  = 1'b1;
            nxt_addr = cb_addr_ff + cfg_cmd_pkg::CFG_WORD_OFFSET;
          end else begin
            nxt_bad = 1'b1;
            nxt_st  = cfg_cmd_pkg::ST_WRITE_ST;
          end
        end
      end
      cfg_cmd_pkg::ST_FETCH_CFG: begin
        if (MEM_ACK) begin
          nxt_req  = 1'b0;
          nxt_word = MEM_RDATA;
          nxt_st   = cfg_cmd_pkg::ST_SEND;
          if (idx_ff == 5'h00) begin
            // Byte 0 carries the count; clamp it to the supported range.
            if (MEM_RDATA[5:0] > {1'b0, cfg_cmd_pkg::CFG_MAX_BYTES}) begin
              nxt_cnt = cfg_cmd_pkg::CFG_MAX_BYTES;
            end else if (MEM_RDATA[5:0] < {1'b0, cfg_cmd_pkg::CFG_MIN_BYTES}) begin
              nxt_cnt = cfg_cmd_pkg::CFG_MIN_BYTES;
            end else begin
              nxt_cnt = MEM_RDATA[4:0];
            end
          end
        end
      end
      cfg_cmd_pkg::ST_SEND: begin
        if (txv_ff) begin
          if (TX_READY) begin
            nxt_txv = 1'b0;
            nxt_idx = idx_inc;
            if (idx_ff[1:0] == 2'h3 && idx_inc < cnt_ff) begin
              nxt_st   = cfg_cmd_pkg::ST_FETCH_CFG;
              nxt_req  = 1'b1;
              nxt_addr = addr_ff + 32'h0000_0004;
            end
          end
        end else if (idx_ff >= cnt_ff) begin
          // Positions past the count are never read or forwarded. The status write is raised in
          // its own state, so its data carry the completion bits from the first cycle the request is seen.
          nxt_st    = cfg_cmd_pkg::ST_WRITE_ST;
        end else if (idx_ff < cfg_cmd_pkg::CU_BYTES) begin
          store_bus.we = 1'b1;
          if (idx_ff[2:0] == cfg_cmd_pkg::RXDMA_BYTE) begin
            nxt_rxmax = cur_byte[cfg_cmd_pkg::RXDMA_W-1:0];
          end
          nxt_idx = idx_inc;
          if (idx_ff[1:0] == 2'h3 && idx_inc < cnt_ff) begin
            nxt_st   = cfg_cmd_pkg::ST_FETCH_CFG;
            nxt_req  = 1'b1;
            nxt_addr = addr_ff + 32'h0000_0004;
          end
        end else begin
          nxt_txv = 1'b1;
          nxt_txd = cur_byte;
          if (idx_ff == cfg_cmd_pkg::PHY_BYTE) begin
            nxt_phyw = 1'b1;
            nxt_phys = cur_byte[cfg_cmd_pkg::PHY_BIT];
          end
        end
      end
      cfg_cmd_pkg::ST_WRITE_ST: begin
        if (!req_ff) begin
          nxt_req   = 1'b1;
          nxt_we    = 1'b1;
          nxt_addr  = cb_addr_ff;
          nxt_wdata = cmd_ff;
        end
        nxt_wdata[cfg_cmd_pkg::DONE_BIT] = 1'b1;
        nxt_wdata[cfg_cmd_pkg::OK_BIT]   = ~bad_ff;
        if (req_ff && MEM_ACK) begin
          nxt_req = 1'b0;
          nxt_we  = 1'b0;
          nxt_st  = cfg_cmd_pkg::ST_FINISH;
        end
      end
      cfg_cmd_pkg::ST_FINISH: begin
        nxt_st = cfg_cmd_pkg::ST_IDLE;
        iset[cfg_cmd_pkg::IRQ_CX_BIT] = cmd_ff[cfg_cmd_pkg::INTR_BIT];
        if (cmd_ff[cfg_cmd_pkg::EOL_BIT]) begin
          nxt_cu = cfg_cmd_pkg::CU_IDLE;
          iset[cfg_cmd_pkg::IRQ_CNA_BIT] = 1'b1;
        end else if (cmd_ff[cfg_cmd_pkg::SUSPEND_BIT]) begin
          nxt_cu = cfg_cmd_pkg::CU_SUSPENDED;
          iset[cfg_cmd_pkg::IRQ_CNA_BIT] = cna_susp_ff;
        end else begin
          nxt_cu = cfg_cmd_pkg::CU_IDLE;
        end
      end
      default: begin
        nxt_st  = cfg_cmd_pkg::ST_IDLE;
        nxt_req = 1'b0;
        nxt_txv = 1'b0;
      end
    endcase
    nxt_link = LATER_GEN ? nxt_phys : nxt_phyw;
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_ff       <= cfg_cmd_pkg::ST_IDLE;
      cu_ff       <= cfg_cmd_pkg::CU_IDLE;
      cb_addr_ff  <= 32'h0000_0000;
      cmd_ff      <= 32'h0000_0000;
      word_ff     <= 32'h0000_0000;
      idx_ff      <= 5'h00;
      cnt_ff      <= cfg_cmd_pkg::CFG_MIN_BYTES;
      bad_ff      <= 1'b0;
      req_ff      <= 1'b0;
      we_ff       <= 1'b0;
      addr_ff     <= 32'h0000_0000;
      wdata_ff    <= 32'h0000_0000;
      txv_ff      <= 1'b0;
      txd_ff      <= 8'h00;
      rxmax_ff    <= cfg_cmd_pkg::RXDMA_DEFAULT;
      phyw_ff     <= 1'b0;
      phys_ff     <= 1'b0;
      link_ff     <= 1'b0;
      cna_susp_ff <= 1'b0;
      ist_ff      <= '0;
      imask_ff    <= '0;
      irq_ff      <= 1'b0;
      cfg_idx_ff  <= 3'h0;
      ack_ff      <= 1'b0;
      rd_ff       <= 32'h0000_0000;
    end else begin
      st_ff       <= nxt_st;
      cu_ff       <= nxt_cu;
      cb_addr_ff  <= nxt_cb_addr;
      cmd_ff      <= nxt_cmd;
      word_ff     <= nxt_word;
      idx_ff      <= nxt_idx;
      cnt_ff      <= nxt_cnt;
      bad_ff      <= nxt_bad;
      req_ff      <= nxt_req;
      we_ff       <= nxt_we;
      addr_ff     <= nxt_addr;
      wdata_ff    <= nxt_wdata;
      txv_ff      <= nxt_txv;
      txd_ff      <= nxt_txd;
      rxmax_ff    <= nxt_rxmax;
      phyw_ff     <= nxt_phyw;
      phys_ff     <= nxt_phys;
      link_ff     <= nxt_link;
      cna_susp_ff <= nxt_cna_susp;
      ist_ff      <= nxt_ist;
      imask_ff    <= nxt_imask;
      irq_ff      <= nxt_irq;
      cfg_idx_ff  <= nxt_cfg_idx;
      ack_ff      <= nxt_ack;
      rd_ff       <= nxt_rd;
    end
  end

  assign WB_DAT_O   = rd_ff;
  assign WB_ACK_O   = ack_ff;
  assign MEM_REQ    = req_ff;
  assign MEM_WE     = we_ff;
  assign MEM_ADDR   = addr_ff;
  assign MEM_WDATA  = wdata_ff;
  assign TX_VALID   = txv_ff;
  assign TX_DATA    = txd_ff;
  assign RX_DMA_MAX = rxmax_ff;
  assign LINK_EN    = link_ff;
  assign CU_STATE   = cu_ff;
  assign IRQ        = irq_ff;

endmodule : configure_command_processor

// file: bench/cfg_cmd_checker.sv
// Port-level assertions for the configure command processor.
`timescale 1ns/1ps
module cfg_cmd_checker (
  input wire logic        CLOCK,      // Clock.
  input wire logic        ARST_N,     // Reset, active low.
  input wire logic        WB_CYC_I,   // Bus cycle.
  input wire logic        WB_STB_I,   // Bus strobe.
  input wire logic        WB_ACK_O,   // Bus acknowledge.
  input wire logic [31:0] WB_DAT_O,   // Bus read data.
  input wire logic        MEM_REQ,    // Memory request.
  input wire logic        MEM_WE,     // Memory write.
  input wire logic [31:0] MEM_ADDR,   // Memory address.
  input wire logic [31:0] MEM_WDATA,  // Memory write data.
  input wire logic        MEM_ACK,    // Memory acknowledge.
  input wire logic        TX_VALID,   // Byte valid.
  input wire logic [7:0]  TX_DATA,    // Byte.
  input wire logic        TX_READY,   // Byte taken.
  input wire logic [1:0]  CU_STATE    // Command unit state.
);
  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!ARST_N);

  sequence st_write;
    MEM_REQ && MEM_WE && MEM_ACK;
  endsequence

  a_ack_follows: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("bus request not acknowledged after one cycle");
  a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("bus acknowledge longer than one cycle");
  a_rdata_idle: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
    else $error("read data not zero outside acknowledge");
  a_req_holds: assert property (MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_ADDR) && $stable(MEM_WE)
                                && $stable(MEM_WDATA)) else $error("memory request changed before ack");
  a_tx_holds: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
    else $error("parameter byte changed before taken");
  a_done_bit: assert property (st_write |-> MEM_WDATA[15])
    else $error("status write without completion bit");
  a_ok_bit: assert property (st_write |-> MEM_WDATA[13] == (MEM_WDATA[18:16] == 3'h2))
    else $error("ok bit does not match command code");
  a_eol_idle: assert property (st_write ##0 MEM_WDATA[31] |-> ##[1:4] CU_STATE == 2'h0)
    else $error("command unit not idle after end of list");
  a_susp_state: assert property (st_write ##0 (MEM_WDATA[30] && !MEM_WDATA[31]) |-> ##[1:4] CU_STATE == 2'h2)
    else $error("command unit not suspended");
endmodule : cfg_cmd_checker

bind configure_command_processor cfg_cmd_checker i_chk (
  .CLOCK(CLOCK), .ARST_N(ARST_N), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O),
  .WB_DAT_O(WB_DAT_O), .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA),
  .MEM_ACK(MEM_ACK), .TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .TX_READY(TX_READY), .CU_STATE(CU_STATE));

// file: bench/host_mem_model.sv
// Host memory and execution unit model facing the command processor.
`timescale 1ns/1ps
module host_mem_model (
  input  wire logic        clk,     // Clock.
  input  wire logic        arst_n,  // Reset, active low.
  input  wire logic        req,     // Request.
  input  wire logic        we,      // Write.
  input  wire logic [31:0] addr,    // Byte address.
  input  wire logic [31:0] wdata,   // Write data.
  input  wire logic [1:0]  rnd,     // Random pace from the bench.
  output logic             ack,     // Acknowledge pulse.
  output logic      [31:0] rdata,   // Read data.
  output logic             ready    // Execution unit takes a byte.
);
  logic [31:0] mem [0:63];

  // Blocks are written by the bench; words hold bytes little-endian.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ack <= 1'b0;
      rdata <= 32'h0;
      ready <= 1'b0;
    end else begin
      ready <= rnd[1];
      ack <= req && !ack && rnd[0];
      // Read data is only valid with ack, so it toggles otherwise.
      rdata <= ~rdata;
      if (req && !ack && rnd[0]) begin
        if (we)
          mem[addr[7:2]] <= wdata;
        else
          rdata <= mem[addr[7:2]];
      end
    end
  end
endmodule : host_mem_model

// file: bench/configure_command_processor_test.sv
// Self-checking bench for the configure command processor.
`timescale 1ns/1ps
module configure_command_processor_test;
  // ****************************************************************
  // Signals and instances
  // ****************************************************************
  logic        clk, arst_n, cyc, stb, we, ack, mreq, mwe, mack, txv, txr, link, irq, wr8, phyv, bad;
  logic [7:0]  adr, txd;
  logic [31:0] dat_i, dat_o, maddr, mwdata, mrdata, q;
  logic [1:0]  rnd, cu;
  logic [6:0]  rxmax, rx_x;
  logic [7:0]  cur [0:7];
  logic [31:0] exp_q [$];
  integer      seed;
  int          n_fail, num_checks, n_st;

  configure_command_processor i_dut (
    .CLOCK(clk), .ARST_N(arst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(4'hF), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .MEM_REQ(mreq), .MEM_WE(mwe),
    .MEM_ADDR(maddr), .MEM_WDATA(mwdata), .MEM_ACK(mack), .MEM_RDATA(mrdata), .TX_VALID(txv),
    .TX_DATA(txd), .TX_READY(txr), .RX_DMA_MAX(rxmax), .LINK_EN(link), .CU_STATE(cu), .IRQ(irq));
  host_mem_model i_mem (.clk(clk), .arst_n(arst_n), .req(mreq), .we(mwe), .addr(maddr), .wdata(mwdata),
    .rnd(rnd), .ack(mack), .rdata(mrdata), .ready(txr));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_i <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    q = dat_o;
    if (n >= 40) begin
      n_fail++;
      test_done();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task automatic cu_bytes();
    for (int i = 0; i < 8; i++) begin
      wb(1'b1, cfg_cmd_pkg::REG_CFG_IDX, i);
      wb(1'b0, cfg_cmd_pkg::REG_CFG_DATA, 32'h0);
      check(q, cur[i]);
    end
  endtask : cu_bytes

  task automatic run(input logic [31:0] cmd, input logic [7:0] cnt, input logic phy, input logic ctl,
                     input logic [1:0] msk);
    logic [7:0] b [0:23];
    logic [1:0] cux, ev;
    logic       cfg;
    int         n, k;
    cfg = cmd[18:16] == 3'h2;
    n = cnt[5:0] < 8 ? 8 : (cnt[5:0] > 22 ? 22 : int'(cnt[5:0]));
    for (int i = 0; i < 24; i++) b[i] = (i < n) ? 8'($random(seed)) : 8'h00;
    b[0] = cnt;
    b[3] = 8'h00;
    if (n > 8) b[8][0] = phy;
    i_mem.mem[16] = cmd;
    i_mem.mem[17] = 32'h0;
    for (int j = 0; j < 6; j++) i_mem.mem[18+j] = {b[4*j+3], b[4*j+2], b[4*j+1], b[4*j]};
    i_mem.mem[24] = $random(seed);
    if (cfg) for (int i = 8; i < n; i++) exp_q.push_back({24'h0, b[i]});
    exp_q.push_back(cmd | (cfg ? 32'hA000 : 32'h8000));
    k = n_st;
    wb(1'b1, cfg_cmd_pkg::REG_IRQ_MASK, 32'(msk));
    wb(1'b1, cfg_cmd_pkg::REG_CB_ADDR, 32'h40);
    wb(1'b1, cfg_cmd_pkg::REG_CTRL, {30'h0, ctl, 1'b1});
    for (int w = 0; w < 3000 && n_st == k; w++) @(posedge clk);
    if (n_st == k) begin
      n_fail++;
      test_done();
    end
    repeat (4) @(posedge clk);
    if (cfg) begin
      for (int i = 0; i < 8; i++) cur[i] = b[i];
      rx_x = b[4][6:0];
      if (n > 8) begin
        wr8 = 1'b1;
        phyv = phy;
      end
    end
    bad = !cfg;
    cux = (cmd[30] && !cmd[31]) ? 2'h2 : 2'h0;
    ev = {cmd[31] | (cmd[30] & ctl), cmd[29]};
    check(cu, cux);
    check(rxmax, rx_x);
    check(link, phyv);
    check(irq, |(ev & msk));
    wb(1'b0, cfg_cmd_pkg::REG_STATUS, 32'h0);
    check(q, {26'h0, bad, phyv, wr8, phyv, cux});
    wb(1'b0, cfg_cmd_pkg::REG_IRQ_STAT, 32'h0);
    check(q, ev);
    wb(1'b1, cfg_cmd_pkg::REG_IRQ_STAT, 32'h3);
    wb(1'b0, cfg_cmd_pkg::REG_IRQ_STAT, 32'h0);
    check(q, 32'h0);
    check(irq, 1'b0);
    cu_bytes();
  endtask : run

  // ****************************************************************
  // Monitor and main sequence
  // ****************************************************************
  always @(posedge clk) begin
    rnd <= 2'($random(seed));
    if (arst_n && txv && txr) check({24'h0, txd}, exp_q.pop_front());
    if (arst_n && mreq && mwe && mack) begin
      check(mwdata, exp_q.pop_front());
      n_st++;
    end
  end

  initial begin
    seed = 32'h6AF90FA2;
    {arst_n, cyc, stb, we, adr, dat_i, wr8, phyv, bad, rx_x} = '0;
    n_fail = 0;
    num_checks = 0;
    n_st = 0;
    for (int i = 0; i < 8; i++) cur[i] = cfg_cmd_pkg::CU_CFG_DEFAULT[8*i +: 8];
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    check(link, 1'b0);
    wb(1'b0, 8'h3C, 32'h0);
    check(q, 32'h0);
    cu_bytes();
    run(32'hA002_0000, 8'h3F, 1'b1, 1'b0, 2'h3);
    run(32'h4002_0000, 8'h08, 1'b0, 1'b0, 2'h3);
    run(32'h6002_0000, 8'h0C, 1'b0, 1'b1, 2'h0);
    run(32'h8000_0000, 8'h16, 1'b1, 1'b0, 2'h2);
    run(32'h0002_0000, 8'h16, 1'b1, 1'b0, 2'h1);
    check(exp_q.size(), 32'h0);
    test_done();
  end
endmodule : configure_command_processor_test
